// >>> src/fpx_defines.vh
// Constants shared by the floating-point exception condition unit
`ifndef FPX_DEFINES_VH
`define FPX_DEFINES_VH

// Register byte offsets
`define FPX_CSR_OFFSET 8'h00
`define FPX_STATUS_OFFSET 8'h04

// Control and status register fields
`define FPX_FLAG_LSB 0
`define FPX_FLAG_MSB 5
`define FPX_MASK_LSB 7
`define FPX_MASK_MSB 12
`define FPX_RC_LSB 13
`define FPX_RC_MSB 14
`define FPX_CSR_RESET 32'h00001F80
`define FPX_CSR_WMASK 32'h00007FBF
`define FPX_MASKS_RESET 6'h3F

// Status register fields
`define FPX_ST_C1_BIT 0
`define FPX_ST_HREQ_BIT 1
`define FPX_ST_LAST_LSB 8
`define FPX_ST_LAST_MSB 13

// Condition positions inside a six-bit flag or mask group
`define FPX_C_INV 0
`define FPX_C_DEN 1
`define FPX_C_ZDV 2
`define FPX_C_OVF 3
`define FPX_C_UNF 4
`define FPX_C_PRE 5
`define FPX_NCOND 6

// Rounding control encodings
`define FPX_RC_NEAREST 2'h0
`define FPX_RC_DOWN 2'h1
`define FPX_RC_UP 2'h2
`define FPX_RC_ZERO 2'h3

// Destination formats
`define FPX_FMT_SINGLE 2'h0
`define FPX_FMT_DOUBLE 2'h1
`define FPX_FMT_EXT 2'h2

// Result selection codes
`define FPX_RES_ROUNDED 3'h0
`define FPX_RES_KEEP 3'h1
`define FPX_RES_QNAN 3'h2
`define FPX_RES_INF 3'h3
`define FPX_RES_MAXFIN 3'h4
`define FPX_RES_TINY 3'h5
`define FPX_RES_BIASED 3'h6

// Unbiased exponent of the unbounded rounded result, 18-bit two's complement
`define FPX_EXP_W 18
`define FPX_OVF_EXP_SINGLE 18'h00080
`define FPX_OVF_EXP_DOUBLE 18'h00400
`define FPX_OVF_EXP_EXT 18'h04000
`define FPX_TINY_EXP_SINGLE 18'h3FF82
`define FPX_TINY_EXP_DOUBLE 18'h3FC02
`define FPX_TINY_EXP_EXT 18'h3C002

// AXI responses
`define FPX_RESP_OKAY 2'h0
`define FPX_RESP_SLVERR 2'h2

`endif

// >>> src/fpx_range_check.v
// Overflow and tininess thresholds on the unbounded-exponent rounded result
`timescale 1ns/1ps
`include "fpx_defines.vh"

module fpx_range_check (
	// Result description
	input wire [1:0] fmt,
	input wire [`FPX_EXP_W-1:0] res_exp,
	input wire res_zero,
	// Range verdict
	output reg overflow,
	output reg tiny
);

	reg [`FPX_EXP_W-1:0] ovf_exp;
	reg [`FPX_EXP_W-1:0] tiny_exp;

	always @* begin
		case (fmt)
			`FPX_FMT_SINGLE: begin
				ovf_exp = `FPX_OVF_EXP_SINGLE;
				tiny_exp = `FPX_TINY_EXP_SINGLE;
			end
			`FPX_FMT_DOUBLE: begin
				ovf_exp = `FPX_OVF_EXP_DOUBLE;
				tiny_exp = `FPX_TINY_EXP_DOUBLE;
			end
			default: begin
				ovf_exp = `FPX_OVF_EXP_EXT;
				tiny_exp = `FPX_TINY_EXP_EXT;
			end
		endcase
		// Magnitude 1.f * 2^e is at or above 2^emax+1
		overflow = !res_zero && ($signed(res_exp) >= $signed(ovf_exp));
		// Non-zero and strictly below the smallest normal
		tiny = !res_zero && ($signed(res_exp) < $signed(tiny_exp));
	end

endmodule

// >>> src/fpx_exc_unit.v
// Floating-point exception condition unit with AXI4-Lite control and status
//
// Overview of operation
// - Masked invalid: set flag, write QNaN
// - Unmasked invalid: set flag, handler, keep operands
// - Masked denormal operand: set flag, continue
// - Unmasked denormal: set flag, handler, keep operands
// - Zero divide on finite non-zero dividend
// - Masked zero divide: flag, infinity XOR sign
// - Unmasked zero divide: flag, handler, keep operands
// - Overflow at 2^128, 2^1024, 2^16384
// - Masked overflow result by rounding mode, sign
// - Unmasked overflow: handler; SIMD keeps, stack biases
// - Tiny: non-zero, below smallest normal, unbounded
// - Masked underflow flags only tiny and inexact
// - Unmasked underflow on any tiny; handler requested
// - Inexact when result not exactly representable
// - Masked inexact alone: flag, store rounded
// - Unmasked inexact alone: flag, rounded, handler
// - Inexact with masked over/underflow sets both
// - Unmasked over/underflow to register: both flags
// - Unmasked over/underflow store: no inexact, clear bit
// - Rounding mode from two-bit control field
// - Flags sticky until software clears them
// - Flags bits 0-5, masks bits 7-12
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fpx_defines.vh"

module fpx_exc_unit #(
	parameter ADDR_W = 8
) (
	// Clock and reset
	input wire clk,
	input wire reset,
	// AXI4-Lite write address
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Operation from the arithmetic datapath
	input wire op_valid,
	input wire op_stack_unit,
	input wire op_dest_memory,
	input wire op_invalid,
	input wire op_denormal,
	input wire op_divide,
	input wire op_divisor_zero,
	input wire op_dividend_finite_nonzero,
	input wire op_sign_a,
	input wire op_sign_b,
	input wire [1:0] op_fmt,
	input wire [`FPX_EXP_W-1:0] op_res_exp,
	input wire op_res_zero,
	input wire op_res_sign,
	input wire op_res_inexact,
	input wire op_rounded_up,
	// Control towards the datapath
	output reg [1:0] round_control_field,
	// Verdict towards result write-back and exception dispatch
	output reg res_valid,
	output reg [2:0] res_select,
	output reg res_sign,
	output reg res_write,
	output reg [5:0] res_flags,
	output reg handler_req,
	output reg condition_bit_one
);

	// Architectural state
	reg [5:0] flags_ff;
	reg [5:0] masks_ff;
	reg [1:0] rc_ff;
	reg c1_ff;
	reg hreq_seen_ff;
	reg [5:0] last_ff;

	// Bus state
	reg aw_hold_ff;
	reg w_hold_ff;
	reg [ADDR_W-1:0] awaddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0] wstrb_ff;
	reg awready_ff;
	reg wready_ff;
	reg bvalid_ff;
	reg [1:0] bresp_ff;
	reg arready_ff;
	reg rvalid_ff;
	reg [31:0] rdata_ff;
	reg [1:0] rresp_ff;

	// Verdict registers
	reg res_valid_ff;
	reg [2:0] res_select_ff;
	reg res_sign_ff;
	reg res_write_ff;
	reg [5:0] res_flags_ff;
	reg handler_req_ff;

	// Range check of the unbounded result
	wire range_ovf;
	wire range_tiny;

	fpx_range_check u_range (
		.fmt(op_fmt),
		.res_exp(op_res_exp),
		.res_zero(op_res_zero),
		.overflow(range_ovf),
		.tiny(range_tiny)
	);

	// Condition detection
	reg c_inv;
	reg c_den;
	reg c_zdv;
	reg pre_stop;
	reg post_ok;
	reg c_ovf;
	reg c_tiny;
	reg c_inx;
	reg c_unf;
	reg store_drop;
	reg c_pre;
	reg [5:0] ev_flags;
	reg ev_hreq;
	reg [2:0] nxt_select;
	reg nxt_sign;
	reg nxt_c1;

	always @* begin
		c_inv = op_valid && op_invalid;
		c_den = op_valid && op_denormal && !op_invalid;
		c_zdv = op_valid && !op_invalid && op_divide && op_divisor_zero
			&& op_dividend_finite_nonzero;
		// Unmasked pre-computation conditions stop the operation before any result
		pre_stop = (c_inv && !masks_ff[`FPX_C_INV])
			|| (c_den && !masks_ff[`FPX_C_DEN])
			|| (c_zdv && !masks_ff[`FPX_C_ZDV]);
		post_ok = op_valid && !c_inv && !c_zdv && !pre_stop;
		c_ovf = post_ok && range_ovf;
		c_tiny = post_ok && range_tiny;
		c_inx = post_ok && op_res_inexact;
		// Masked underflow needs tiny and inexact, unmasked needs only tiny
		c_unf = c_tiny && (c_inx || !masks_ff[`FPX_C_UNF]);
		store_drop = op_dest_memory && ((c_ovf && !masks_ff[`FPX_C_OVF])
			|| (c_unf && !masks_ff[`FPX_C_UNF]));
		c_pre = c_inx && !store_drop;
		ev_flags = 6'h00;
		ev_flags[`FPX_C_INV] = c_inv;
		ev_flags[`FPX_C_DEN] = c_den;
		ev_flags[`FPX_C_ZDV] = c_zdv;
		ev_flags[`FPX_C_OVF] = c_ovf;
		ev_flags[`FPX_C_UNF] = c_unf;
		ev_flags[`FPX_C_PRE] = c_pre;
		ev_hreq = |(ev_flags & ~masks_ff);
		nxt_sign = op_res_sign;
		if (c_inv) begin
			nxt_select = masks_ff[`FPX_C_INV] ? `FPX_RES_QNAN : `FPX_RES_KEEP;
		end else if (c_zdv) begin
			nxt_select = masks_ff[`FPX_C_ZDV] ? `FPX_RES_INF : `FPX_RES_KEEP;
			nxt_sign = op_sign_a ^ op_sign_b;
		end else if (pre_stop) begin
			nxt_select = `FPX_RES_KEEP;
		end else if (c_ovf) begin
			if (masks_ff[`FPX_C_OVF]) begin
				case (rc_ff)
					`FPX_RC_NEAREST: nxt_select = `FPX_RES_INF;
					`FPX_RC_DOWN: nxt_select = op_res_sign ? `FPX_RES_INF : `FPX_RES_MAXFIN;
					`FPX_RC_UP: nxt_select = op_res_sign ? `FPX_RES_MAXFIN : `FPX_RES_INF;
					default: nxt_select = `FPX_RES_MAXFIN;
				endcase
			end else begin
				nxt_select = op_stack_unit ? `FPX_RES_BIASED : `FPX_RES_KEEP;
			end
		end else if (c_tiny) begin
			if (masks_ff[`FPX_C_UNF]) begin
				nxt_select = `FPX_RES_TINY;
			end else begin
				nxt_select = op_stack_unit ? `FPX_RES_BIASED : `FPX_RES_KEEP;
			end
		end else begin
			nxt_select = `FPX_RES_ROUNDED;
		end
		// Stack-unit condition bit one follows round-up unless a store is dropped
		if (!op_valid || !op_stack_unit) begin
			nxt_c1 = c1_ff;
		end else if (store_drop) begin
			nxt_c1 = 1'b0;
		end else begin
			nxt_c1 = c_pre && op_rounded_up;
		end
	end

	// Bus handshakes
	wire aw_take = s_axi_awvalid && awready_ff;
	wire w_take = s_axi_wvalid && wready_ff;
	wire do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
	wire ar_take = s_axi_arvalid && arready_ff;
	wire [ADDR_W-1:0] csr_addr = `FPX_CSR_OFFSET;
	wire [ADDR_W-1:0] st_addr = `FPX_STATUS_OFFSET;
	wire wr_csr = do_write && (awaddr_ff[ADDR_W-1:2] == csr_addr[ADDR_W-1:2]);
	wire wr_st = do_write && (awaddr_ff[ADDR_W-1:2] == st_addr[ADDR_W-1:2]);

	reg nxt_aw_hold;
	reg nxt_w_hold;
	reg nxt_bvalid;
	reg nxt_rvalid;
	reg [31:0] csr_word;
	reg [31:0] csr_new;
	reg [31:0] st_word;
	reg [31:0] nxt_rdata;
	reg [1:0] nxt_rresp;
	integer i;

	always @* begin
		nxt_aw_hold = do_write ? 1'b0 : (aw_hold_ff || aw_take);
		nxt_w_hold = do_write ? 1'b0 : (w_hold_ff || w_take);
		nxt_bvalid = do_write ? 1'b1 : (bvalid_ff && !s_axi_bready);
		nxt_rvalid = ar_take ? 1'b1 : (rvalid_ff && !s_axi_rready);
		csr_word = 32'h00000000;
		csr_word[`FPX_FLAG_MSB:`FPX_FLAG_LSB] = flags_ff;
		csr_word[`FPX_MASK_MSB:`FPX_MASK_LSB] = masks_ff;
		csr_word[`FPX_RC_MSB:`FPX_RC_LSB] = rc_ff;
		for (i = 0; i < 4; i = i + 1) begin
			csr_new[i*8 +: 8] = wstrb_ff[i] ? wdata_ff[i*8 +: 8] : csr_word[i*8 +: 8];
		end
		csr_new = csr_new & `FPX_CSR_WMASK;
		st_word = 32'h00000000;
		st_word[`FPX_ST_C1_BIT] = c1_ff;
		st_word[`FPX_ST_HREQ_BIT] = hreq_seen_ff;
		st_word[`FPX_ST_LAST_MSB:`FPX_ST_LAST_LSB] = last_ff;
		nxt_rresp = `FPX_RESP_OKAY;
		if (s_axi_araddr[ADDR_W-1:2] == csr_addr[ADDR_W-1:2]) begin
			nxt_rdata = csr_word;
		end else if (s_axi_araddr[ADDR_W-1:2] == st_addr[ADDR_W-1:2]) begin
			nxt_rdata = st_word;
		end else begin
			nxt_rdata = 32'h00000000;
			nxt_rresp = `FPX_RESP_SLVERR;
		end
	end

	// Bus slave registers
	always @(posedge clk) begin
		if (reset) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awaddr_ff <= {ADDR_W{1'b0}};
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `FPX_RESP_OKAY;
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `FPX_RESP_OKAY;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff <= nxt_w_hold;
			if (aw_take) begin
				awaddr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			awready_ff <= !nxt_aw_hold && !nxt_bvalid;
			wready_ff <= !nxt_w_hold && !nxt_bvalid;
			bvalid_ff <= nxt_bvalid;
			if (do_write) begin
				bresp_ff <= (wr_csr || wr_st) ? `FPX_RESP_OKAY : `FPX_RESP_SLVERR;
			end
			arready_ff <= !nxt_rvalid;
			rvalid_ff <= nxt_rvalid;
			if (ar_take) begin
				rdata_ff <= nxt_rdata;
				rresp_ff <= nxt_rresp;
			end
		end
	end

	// Control and status state; a hardware set wins over a software clear
	always @(posedge clk) begin
		if (reset) begin
			flags_ff <= 6'h00;
			masks_ff <= `FPX_MASKS_RESET;
			rc_ff <= `FPX_RC_NEAREST;
			c1_ff <= 1'b0;
			hreq_seen_ff <= 1'b0;
			last_ff <= 6'h00;
		end else begin
			if (wr_csr) begin
				flags_ff <= csr_new[`FPX_FLAG_MSB:`FPX_FLAG_LSB] | ev_flags;
				masks_ff <= csr_new[`FPX_MASK_MSB:`FPX_MASK_LSB];
				rc_ff <= csr_new[`FPX_RC_MSB:`FPX_RC_LSB];
			end else begin
				flags_ff <= flags_ff | ev_flags;
			end
			c1_ff <= nxt_c1;
			if (op_valid) begin
				last_ff <= ev_flags;
			end
			// Writing a one to the handler-seen bit clears it
			if (ev_hreq) begin
				hreq_seen_ff <= 1'b1;
			end else if (wr_st && wstrb_ff[0] && wdata_ff[`FPX_ST_HREQ_BIT]) begin
				hreq_seen_ff <= 1'b0;
			end
		end
	end

	// Per-operation verdict, all fields updated in the same edge
	always @(posedge clk) begin
		if (reset) begin
			res_valid_ff <= 1'b0;
			res_select_ff <= `FPX_RES_ROUNDED;
			res_sign_ff <= 1'b0;
			res_write_ff <= 1'b0;
			res_flags_ff <= 6'h00;
			handler_req_ff <= 1'b0;
		end else begin
			res_valid_ff <= op_valid;
			res_select_ff <= op_valid ? nxt_select : `FPX_RES_ROUNDED;
			res_sign_ff <= op_valid && nxt_sign;
			res_write_ff <= op_valid && (nxt_select != `FPX_RES_KEEP);
			res_flags_ff <= ev_flags;
			handler_req_ff <= ev_hreq;
		end
	end

	// Output ports
	always @* begin
		s_axi_awready = awready_ff;
		s_axi_wready = wready_ff;
		s_axi_bvalid = bvalid_ff;
		s_axi_bresp = bresp_ff;
		s_axi_arready = arready_ff;
		s_axi_rvalid = rvalid_ff;
		s_axi_rdata = rdata_ff;
		s_axi_rresp = rresp_ff;
		round_control_field = rc_ff;
		res_valid = res_valid_ff;
		res_select = res_select_ff;
		res_sign = res_sign_ff;
		res_write = res_write_ff;
		res_flags = res_flags_ff;
		handler_req = handler_req_ff;
		condition_bit_one = c1_ff;
	end

endmodule

// >>> tb/fpx_dp_model.sv
// Datapath model that turns a bench command into one operation pulse
`timescale 1ns/1ps
module fpx_dp_model (
	// Clock
	input wire logic clk,
	// Command from the bench
	input wire logic go,
	input wire logic [32:0] cmd,
	// Operation towards the unit
	output logic op_valid,
	output logic [32:0] op_bus
);
	// Fields are inverted outside the pulse so stale values never look valid
	always @(posedge clk) begin
		op_valid <= go;
		op_bus <= go ? cmd : ~cmd;
	end
endmodule

// >>> tb/fpx_exc_unit_assertions.sv
// Checker for the exception condition unit
`timescale 1ns/1ps
module fpx_exc_chk (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Operation
	input wire op_valid,
	input wire op_invalid,
	input wire op_denormal,
	input wire op_divide,
	input wire op_divisor_zero,
	input wire op_dividend_finite_nonzero,
	input wire op_sign_a,
	input wire op_sign_b,
	input wire [1:0] op_fmt,
	input wire [17:0] op_res_exp,
	input wire op_res_zero,
	input wire op_res_inexact,
	// Verdict
	input wire res_valid,
	input wire [2:0] res_select,
	input wire res_sign,
	input wire [5:0] res_flags,
	input wire handler_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	wire zd = op_divide && op_divisor_zero && op_dividend_finite_nonzero && !op_invalid;
	wire sx = op_sign_a ^ op_sign_b;
	wire post = op_valid && !op_invalid && !op_denormal && !zd && !op_res_zero && op_fmt == 2'h0;
	sequence s_op;
		op_valid;
	endsequence
	sequence s_done;
		##1 res_valid;
	endsequence
	a_res_latency: assert property (s_op |-> s_done)
		else $error("no result one cycle after op");
	a_res_cause: assert property (res_valid |-> $past(op_valid))
		else $error("result without op");
	a_hreq_with: assert property (handler_req |-> res_valid)
		else $error("handler request alone");
	a_inv_flag: assert property (op_valid && op_invalid |=> res_flags[0] && res_select inside {3'h1, 3'h2})
		else $error("invalid not reported");
	a_den_flag: assert property (op_valid && op_denormal && !op_invalid |=> res_flags[1])
		else $error("denormal not reported");
	a_zdiv_flag: assert property (op_valid && zd && !op_denormal |=> res_flags[2])
		else $error("zero divide not reported");
	a_zdiv_sign: assert property (op_valid && zd && !op_denormal |=> res_select == 3'h1 || res_sign == $past(sx))
		else $error("zero divide sign wrong");
	a_ovf_single: assert property (post && $signed(op_res_exp) >= 128 |=> res_flags[3])
		else $error("overflow missed");
	a_tiny_single: assert property (post && op_res_inexact && $signed(op_res_exp) < -126 |=> res_flags[4])
		else $error("underflow missed");
endmodule
bind fpx_exc_unit fpx_exc_chk u_chk (.clk, .reset, .op_valid, .op_invalid, .op_denormal, .op_divide,
	.op_divisor_zero, .op_dividend_finite_nonzero, .op_sign_a, .op_sign_b, .op_fmt, .op_res_exp,
	.op_res_zero, .op_res_inexact, .res_valid, .res_select, .res_sign, .res_flags, .handler_req);

// >>> tb/tb_fp_exception_condition_unit.sv
// Self-checking bench for the exception condition unit
`timescale 1ns/1ps
module tb_fp_exception_condition_unit;
	localparam logic [8:0] STK = 9'h100, MEM = 9'h080, INV = 9'h040, DEN = 9'h020;
	localparam logic [8:0] ZD = 9'h01C, SA = 9'h002, SB = 9'h001;
	localparam logic [3:0] ZERO = 4'h8, NEG = 4'h4, INX = 4'h2, UP = 4'h1;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, go = 1'b0;
	logic [32:0] cmd = 33'h0;
	wire awready, wready, bvalid, arready, rvalid, op_valid, res_valid, res_sign, handler_req, cbit;
	wire res_write;
	wire [1:0] bresp, rresp, rcf;
	wire [31:0] rdata;
	wire [32:0] ob;
	wire [2:0] res_select;
	wire [5:0] res_flags;
	int err_total = 0, n_compared = 0, cyc = 0;
	always #10 clk = ~clk;
	fpx_dp_model u_dp (.clk(clk), .go(go), .cmd(cmd), .op_valid(op_valid), .op_bus(ob));
	fpx_exc_unit DUT (.clk(clk), .reset(reset),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.op_valid(op_valid), .op_stack_unit(ob[32]), .op_dest_memory(ob[31]), .op_invalid(ob[30]),
		.op_denormal(ob[29]), .op_divide(ob[28]), .op_divisor_zero(ob[27]),
		.op_dividend_finite_nonzero(ob[26]), .op_sign_a(ob[25]), .op_sign_b(ob[24]),
		.op_fmt(ob[23:22]), .op_res_exp(ob[21:4]), .op_res_zero(ob[3]), .op_res_sign(ob[2]),
		.op_res_inexact(ob[1]), .op_rounded_up(ob[0]), .round_control_field(rcf),
		.res_valid(res_valid), .res_select(res_select), .res_sign(res_sign), .res_write(res_write),
		.res_flags(res_flags), .handler_req(handler_req), .condition_bit_one(cbit));
	function logic [32:0] mk(input logic [8:0] k, input logic [1:0] f, input logic [17:0] e,
		input logic [3:0] t);
		mk = {k, f, e, t};
	endfunction
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		begin
			n_compared++;
			if (g !== e) begin
				err_total++;
				$display("[ERR] %s expected %h seen %h", n, e, g);
			end
		end
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			do begin
				@(negedge clk);
				ta = awvalid && awready;
				tw = wvalid && wready;
				@(posedge clk);
				if (ta)
					awvalid <= 1'b0;
				if (tw)
					wvalid <= 1'b0;
			end while (awvalid && !ta || wvalid && !tw);
			bready <= 1'b1;
			do @(negedge clk); while (bvalid !== 1'b1);
			chk("bresp", 2'h0, bresp);
			@(posedge clk);
			bready <= 1'b0;
		end
	endtask
	task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		begin
			araddr <= a;
			arvalid <= 1'b1;
			do @(negedge clk); while (arready !== 1'b1);
			@(posedge clk);
			arvalid <= 1'b0;
			rready <= 1'b1;
			do @(negedge clk); while (rvalid !== 1'b1);
			chk("rdata", e, rdata);
			chk("rresp", er, rresp);
			@(posedge clk);
			rready <= 1'b0;
		end
	endtask
	// One operation: result is seen exactly one cycle after the operation pulse
	task run(input logic [32:0] c, input logic [2:0] es, input logic [5:0] ef, input logic eh, sg);
		begin
			cmd <= c;
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			repeat (2) @(negedge clk);
			chk("res_valid", 1'b1, res_valid);
			chk("res_select", es, res_select);
			chk("res_write", es != 3'h1, res_write);
			chk("res_flags", ef, res_flags);
			chk("handler_req", eh, handler_req);
			if (es != 3'h1)
				chk("res_sign", sg, res_sign);
			@(posedge clk);
		end
	endtask
	task print_verdict;
		begin
			$display("compared %0d mismatches %0d", n_compared, err_total);
			if (err_total == 0 && n_compared > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			print_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		axr(8'h00, 32'h00001F80, 2'h0);
		axr(8'h04, 32'h0, 2'h0);
		axr(8'h08, 32'h0, 2'h2);
		$display("test registers done");
		run(mk(INV, 2'h0, 18'h0, 4'h0), 3'h2, 6'h01, 1'b0, 1'b0);
		run(mk(DEN, 2'h0, 18'h0, 4'h0), 3'h0, 6'h02, 1'b0, 1'b0);
		run(mk(ZD | SA, 2'h0, 18'h0, 4'h0), 3'h3, 6'h04, 1'b0, 1'b1);
		run(mk(ZD | SA | SB, 2'h0, 18'h0, 4'h0), 3'h3, 6'h04, 1'b0, 1'b0);
		run(mk(9'h018, 2'h0, 18'h0, 4'h0), 3'h0, 6'h00, 1'b0, 1'b0);
		run(mk(9'h0, 2'h0, 18'h0007F, 4'h0), 3'h0, 6'h00, 1'b0, 1'b0);
		run(mk(9'h0, 2'h1, 18'h003FF, 4'h0), 3'h0, 6'h00, 1'b0, 1'b0);
		run(mk(9'h0, 2'h1, 18'h00400, INX), 3'h3, 6'h28, 1'b0, 1'b0);
		run(mk(9'h0, 2'h2, 18'h03FFF, 4'h0), 3'h0, 6'h00, 1'b0, 1'b0);
		run(mk(9'h0, 2'h2, 18'h04000, INX | NEG), 3'h3, 6'h28, 1'b0, 1'b1);
		run(mk(9'h0, 2'h0, 18'h3FF82, 4'h0), 3'h0, 6'h00, 1'b0, 1'b0);
		run(mk(9'h0, 2'h0, 18'h3FF81, 4'h0), 3'h5, 6'h00, 1'b0, 1'b0);
		run(mk(9'h0, 2'h0, 18'h3FF81, ZERO), 3'h0, 6'h00, 1'b0, 1'b0);
		run(mk(9'h0, 2'h0, 18'h3FF81, INX | NEG), 3'h5, 6'h30, 1'b0, 1'b1);
		run(mk(9'h0, 2'h1, 18'h3FC01, INX), 3'h5, 6'h30, 1'b0, 1'b0);
		run(mk(9'h0, 2'h2, 18'h3C002, 4'h0), 3'h0, 6'h00, 1'b0, 1'b0);
		run(mk(9'h0, 2'h2, 18'h3C001, 4'h0), 3'h5, 6'h00, 1'b0, 1'b0);
		run(mk(9'h0, 2'h0, 18'h0, INX), 3'h0, 6'h20, 1'b0, 1'b0);
		axr(8'h00, 32'h00001FBF, 2'h0);
		$display("test masked done");
		for (int m = 0; m < 8; m++) begin
			axw(8'h00, {17'h0, m[1:0], 13'h1F80});
			@(negedge clk);
			chk("round_control", m[1:0], rcf);
			@(posedge clk);
			run(mk(9'h0, 2'h0, 18'h00080, INX | (m[2] ? NEG : 4'h0)),
				(m[1:0] == 2'h0 || m[1:0] == {~m[2], m[2]}) ? 3'h3 : 3'h4, 6'h28, 1'b0, m[2]);
		end
		$display("test overflow done");
		axw(8'h00, 32'h0);
		axr(8'h00, 32'h0, 2'h0);
		run(mk(INV, 2'h0, 18'h0, 4'h0), 3'h1, 6'h01, 1'b1, 1'b0);
		run(mk(DEN, 2'h0, 18'h0, 4'h0), 3'h1, 6'h02, 1'b1, 1'b0);
		run(mk(ZD, 2'h0, 18'h0, 4'h0), 3'h1, 6'h04, 1'b1, 1'b0);
		run(mk(9'h0, 2'h0, 18'h00080, INX), 3'h1, 6'h28, 1'b1, 1'b0);
		run(mk(STK, 2'h0, 18'h00080, INX), 3'h6, 6'h28, 1'b1, 1'b0);
		run(mk(9'h0, 2'h0, 18'h3FF81, 4'h0), 3'h1, 6'h10, 1'b1, 1'b0);
		run(mk(STK, 2'h0, 18'h0, INX | UP), 3'h0, 6'h20, 1'b1, 1'b0);
		@(negedge clk);
		chk("cond_bit", 1'b1, cbit);
		@(posedge clk);
		run(mk(STK | MEM, 2'h0, 18'h00080, INX | UP), 3'h6, 6'h08, 1'b1, 1'b0);
		@(negedge clk);
		chk("cond_bit", 1'b0, cbit);
		@(posedge clk);
		axr(8'h04, 32'h00000802, 2'h0);
		$display("test unmasked done");
		print_verdict();
	end
endmodule
